// ===== hw/hprt_pkg.sv
// Purpose: shared constants and types of the parallel host port
// Assumes: one clock, core_clk at 125 MHz
// Notes:   strobe widths are expressed in clock periods
package hprt_pkg;

  // ----------------------------------------------------------------
  // widths and access types
  // ----------------------------------------------------------------
  localparam int          HALF_W        = 16;
  localparam int          WORD_W        = 32;
  localparam logic [1:0]  TYPE_CONTROL  = 2'h0;
  localparam logic [1:0]  TYPE_DATA_INC = 2'h1;
  localparam logic [1:0]  TYPE_ADDRESS  = 2'h2;
  localparam logic [1:0]  TYPE_DATA_FIX = 2'h3;

  // ----------------------------------------------------------------
  // reset values and address step
  // ----------------------------------------------------------------
  localparam logic [15:0] CONTROL_RST   = 16'h0000;
  localparam logic [31:0] ADDRESS_RST   = 32'h0000_0000;
  localparam logic [31:0] DATA_RST      = 32'h0000_0000;
  localparam logic [31:0] ADDRESS_STEP  = 32'h0000_0004;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          STB_LOW_MIN_NS  = 4 * CLK_PERIOD_NS;
  localparam int          STB_HIGH_MIN_NS = 4 * CLK_PERIOD_NS;
  localparam int          STB_LOW_CYC     = (STB_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STB_HIGH_CYC    = (STB_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // synchroniser plus edge detect plus output register in the device
  localparam int          SYNC_LAT_CYC    = 3;
  localparam logic [3:0]  HOST_LOW_CNT    = 4'(STB_LOW_CYC + SYNC_LAT_CYC);
  localparam logic [3:0]  HOST_HIGH_CNT   = 4'(STB_HIGH_CYC + SYNC_LAT_CYC);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HPRT_IDLE,
    HPRT_SETUP,
    HPRT_STROBE,
    HPRT_HOLD,
    HPRT_GAP,
    HPRT_DONE
  } hprt_host_state_t;

  typedef struct packed {
    logic [1:0] access_type_select;
    logic       host_read_write;
    logic       halfword_select;
  } hprt_sel_t;

endpackage

// ===== hw/hprt_if.sv
// Purpose: pins between the external host and the host port
// Assumes: both ends run on core_clk
// Notes:   the shared data bus is resolved here from the two enables
interface hprt_if;
  import hprt_pkg::*;

  logic                host_chip_select;
  logic                host_data_strobe_a;
  logic                host_data_strobe_b;
  logic                host_address_strobe;
  logic [1:0]          access_type_select;
  logic                host_read_write;
  logic                halfword_select;
  logic                host_ready_n;
  logic [HALF_W-1:0]   host_data_out;
  logic                host_data_oe_n;
  logic [HALF_W-1:0]   dev_data_out;
  logic                dev_data_oe_n;
  logic [HALF_W-1:0]   host_data_bus;

  // ----------------------------------------------------------------
  // bus level: device wins when it drives, else the host, else zero
  // ----------------------------------------------------------------
  assign host_data_bus = !dev_data_oe_n ? dev_data_out : (!host_data_oe_n ? host_data_out : '0);

  modport device (
    input  host_chip_select, host_data_strobe_a, host_data_strobe_b, host_address_strobe,
    input  access_type_select, host_read_write, halfword_select, host_data_bus,
    output host_ready_n, dev_data_out, dev_data_oe_n
  );

  modport host (
    output host_chip_select, host_data_strobe_a, host_data_strobe_b, host_address_strobe,
    output access_type_select, host_read_write, halfword_select, host_data_out, host_data_oe_n,
    input  host_ready_n, host_data_bus
  );
endinterface

// ===== hw/hprt_sync.sv
// Purpose: two flip-flop level synchroniser, one per bit
// Assumes: inputs are levels that may change at any time
// Notes:   first stage is read by the second stage only
module hprt_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------
  // per-bit stages; reset to one because every strobe idles high
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        meta[i]     <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta[i]     <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  end
endmodule

// ===== hw/hprt_device.sv
// Purpose: device end of the 16-bit parallel host port with ready handshake
// Assumes: strobes and chip select are asynchronous; internal transfers answer on dma_done
// Notes:   first half-word is bits 15:0, second half-word bits 31:16
//
// Overview of operation
// - strobe active when selected, one data strobe low
// - ready held low while chip select high
// - busy shown at select if earlier transfer pending
// - data read first half fetches unless prefetched or an earlier transfer pending, ready high
// - ready high after second half of data write
// - incrementing read second half prefetches, ready high; others keep ready low
// - control and address traffic never touch ready
// - host keeps write strobe until ready low
// - selects sampled at start of each half
// - address strobe fall latches selects instead
// - write half-word captured at strobe rise
// - drive bus after fall, release after rise
// - host pulses address strobe once per access
module hprt_device
  import hprt_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  hprt_if.device                      pins,
  output logic                        dma_req,
  output logic                        dma_write,
  output logic [hprt_pkg::WORD_W-1:0] dma_addr,
  output logic [hprt_pkg::WORD_W-1:0] dma_wdata,
  input  wire logic                   dma_done,
  input  wire logic [hprt_pkg::WORD_W-1:0] dma_rdata,
  output logic [15:0]                 control_value
);
  import hprt_pkg::*;

  // ----------------------------------------------------------------
  // synchronised strobes and aligned select and data pipeline
  // ----------------------------------------------------------------
  logic [3:0]        strobes_s;
  logic              cs_s;
  logic              as_s;
  logic              stb_n;
  logic              stb_prev;
  logic              as_prev;
  hprt_sel_t         sel_p1;
  hprt_sel_t         sel_p2;
  logic [HALF_W-1:0] din_p1;
  logic [HALF_W-1:0] din_p2;

  hprt_sync #(.WIDTH(4)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({pins.host_chip_select, pins.host_data_strobe_a,
                pins.host_data_strobe_b, pins.host_address_strobe}),
    .sync_out (strobes_s)
  );

  assign cs_s  = strobes_s[3];
  assign as_s  = strobes_s[0];
  assign stb_n = ~(strobes_s[2] ^ strobes_s[1]) | cs_s;

  // selects and data delayed to line up with the synchronised edges
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sel_p1 <= '0;
      sel_p2 <= '0;
      din_p1 <= '0;
      din_p2 <= '0;
    end else begin
      sel_p1 <= {pins.access_type_select, pins.host_read_write, pins.halfword_select};
      sel_p2 <= sel_p1;
      din_p1 <= pins.host_data_bus;
      din_p2 <= din_p1;
    end
  end

  // ----------------------------------------------------------------
  // edges and access decode
  // ----------------------------------------------------------------
  function automatic logic is_data(input logic [1:0] t);
    return (t == TYPE_DATA_INC) || (t == TYPE_DATA_FIX);
  endfunction

  logic       stb_fall;
  logic       stb_rise;
  logic       as_fall;
  logic       as_seen;
  hprt_sel_t  sel_lat;
  hprt_sel_t  cur_sel;
  logic       rd_active;
  logic       busy;
  logic       busy_d;
  logic       op_inc;
  logic       op_write;
  logic       prefetch_valid;
  logic [31:0] data_reg;
  logic [31:0] addr_reg;
  logic [15:0] wbuf_low;

  assign stb_fall = stb_prev & ~stb_n;
  assign stb_rise = ~stb_prev & stb_n;
  assign as_fall  = as_prev & ~as_s;
  // without an address strobe the selects come from the strobe fall itself
  assign cur_sel  = (stb_fall && !as_seen) ? sel_p2 : sel_lat;

  wire cur_data   = is_data(cur_sel.access_type_select);
  wire cur_inc    = cur_sel.access_type_select == TYPE_DATA_INC;
  wire rd_fetch   = stb_fall && cur_sel.host_read_write && cur_data
                    && !cur_sel.halfword_select && !prefetch_valid;
  wire rd_prefetch = stb_rise && cur_sel.host_read_write && cur_inc
                    && cur_sel.halfword_select;
  wire wr_rise    = stb_rise && !cur_sel.host_read_write;
  wire wr_commit  = wr_rise && cur_data && cur_sel.halfword_select;
  wire new_req    = rd_fetch || rd_prefetch || wr_commit;
  wire [31:0] next_addr_inc = addr_reg + ADDRESS_STEP;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stb_prev <= 1'b1;
      as_prev  <= 1'b1;
      as_seen  <= 1'b0;
      sel_lat  <= '0;
    end else begin
      stb_prev <= stb_n;
      as_prev  <= as_s;
      if (as_fall) begin
        sel_lat <= sel_p2;
        as_seen <= 1'b1;
      end else if (stb_fall && !as_seen) begin
        sel_lat <= sel_p2;
      end else if (stb_rise) begin
        as_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers and internal transfer requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      control_value  <= CONTROL_RST;
      addr_reg       <= ADDRESS_RST;
      data_reg       <= DATA_RST;
      wbuf_low       <= '0;
      busy           <= 1'b0;
      op_inc         <= 1'b0;
      op_write       <= 1'b0;
      prefetch_valid <= 1'b0;
      dma_req        <= 1'b0;
      dma_write      <= 1'b0;
      dma_addr       <= ADDRESS_RST;
      dma_wdata      <= DATA_RST;
    end else begin
      dma_req <= new_req && !busy;
      if (new_req && !busy) begin
        busy      <= 1'b1;
        op_inc    <= cur_inc;
        op_write  <= wr_commit;
        dma_write <= wr_commit;
        dma_addr  <= addr_reg;
        dma_wdata <= {din_p2, wbuf_low};
      end else if (dma_done && busy) begin
        busy <= 1'b0;
        if (!op_write) begin
          data_reg       <= dma_rdata;
          prefetch_valid <= op_inc;
        end
        if (op_inc) begin
          addr_reg <= next_addr_inc;
        end
      end
      if (stb_fall && cur_sel.host_read_write && cur_data && cur_sel.halfword_select) begin
        prefetch_valid <= 1'b0;
      end
      // host half-word writes, all captured at the strobe rise
      if (wr_rise) begin
        unique case (cur_sel.access_type_select)
          TYPE_CONTROL: control_value <= din_p2;
          TYPE_ADDRESS: begin
            if (cur_sel.halfword_select) begin
              addr_reg[31:16] <= din_p2;
            end else begin
              addr_reg[15:0] <= din_p2;
            end
            prefetch_valid <= 1'b0;
          end
          TYPE_DATA_INC, TYPE_DATA_FIX: begin
            if (!cur_sel.halfword_select) begin
              wbuf_low <= din_p2;
            end
            prefetch_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // ready handshake and read data drive
  // ----------------------------------------------------------------
  // busy_d keeps ready high one cycle past the load so the bus settles first
  hprt_sel_t  rd_sel;
  logic [31:0] rd_word;
  logic [15:0] rd_half;

  assign rd_word = (rd_sel.access_type_select == TYPE_CONTROL) ? {16'h0000, control_value} :
                   (rd_sel.access_type_select == TYPE_ADDRESS) ? addr_reg : data_reg;
  assign rd_half = rd_sel.halfword_select ? rd_word[31:16] : rd_word[15:0];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy_d             <= 1'b0;
      rd_active          <= 1'b0;
      rd_sel             <= '0;
      pins.host_ready_n  <= 1'b0;
      pins.dev_data_out  <= '0;
      pins.dev_data_oe_n <= 1'b1;
    end else begin
      busy_d            <= busy;
      // only data traffic raises busy, so other accesses leave ready low
      pins.host_ready_n <= !cs_s && (busy || busy_d || new_req);
      if (stb_fall) begin
        rd_active <= cur_sel.host_read_write;
        rd_sel    <= cur_sel;
      end else if (stb_rise) begin
        rd_active <= 1'b0;
      end
      pins.dev_data_oe_n <= !(rd_active && !stb_rise);
      pins.dev_data_out  <= rd_half;
    end
  end
endmodule

// ===== hw/hprt_host.sv
// Purpose: external host end, moves one 32-bit word as two half-word accesses
// Assumes: host_ready_n is sampled directly on core_clk
// Notes:   strobe low and high times include the device synchroniser latency
module hprt_host
  import hprt_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  hprt_if.host                        pins,
  input  wire logic                   start,
  input  wire logic                   start_write,
  input  wire logic [1:0]             start_type,
  input  wire logic                   use_address_strobe,
  input  wire logic [hprt_pkg::WORD_W-1:0] start_wdata,
  output logic                        busy,
  output logic                        done,
  output logic [hprt_pkg::WORD_W-1:0] rdata
);
  import hprt_pkg::*;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  hprt_host_state_t state;
  logic [3:0]       cnt;
  logic             half;
  logic             use_as;
  logic [31:0]      wdata;

  wire low_done  = (cnt >= HOST_LOW_CNT) && !pins.host_ready_n;
  wire high_done = cnt >= HOST_HIGH_CNT;
  wire [3:0] next_cnt = cnt + 4'h1;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state                    <= HPRT_IDLE;
      cnt                      <= '0;
      half                     <= 1'b0;
      use_as                   <= 1'b0;
      wdata                    <= '0;
      busy                     <= 1'b0;
      done                     <= 1'b0;
      rdata                    <= '0;
      pins.host_chip_select    <= 1'b1;
      pins.host_data_strobe_a  <= 1'b1;
      pins.host_data_strobe_b  <= 1'b1;
      pins.host_address_strobe <= 1'b1;
      pins.access_type_select  <= '0;
      pins.host_read_write     <= 1'b1;
      pins.halfword_select     <= 1'b0;
      pins.host_data_out       <= '0;
      pins.host_data_oe_n      <= 1'b1;
    end else begin
      done <= 1'b0;
      cnt  <= next_cnt;
      unique case (state)
        HPRT_IDLE: begin
          if (start) begin
            state                   <= HPRT_SETUP;
            busy                    <= 1'b1;
            half                    <= 1'b0;
            use_as                  <= use_address_strobe;
            wdata                   <= start_wdata;
            pins.host_chip_select   <= 1'b0;
            pins.access_type_select <= start_type;
            pins.host_read_write    <= !start_write;
            pins.halfword_select    <= 1'b0;
          end
        end
        HPRT_SETUP: begin
          // selects have stood a full cycle before the strobe falls
          state                    <= HPRT_STROBE;
          cnt                      <= '0;
          pins.host_data_strobe_a  <= 1'b0;
          pins.host_address_strobe <= !use_as;
          pins.host_data_out       <= half ? wdata[31:16] : wdata[15:0];
          pins.host_data_oe_n      <= !pins.host_read_write ? 1'b0 : 1'b1;
        end
        HPRT_STROBE: begin
          pins.host_address_strobe <= 1'b1;
          if (low_done) begin
            state                   <= HPRT_HOLD;
            cnt                     <= '0;
            pins.host_data_strobe_a <= 1'b1;
            if (pins.host_read_write) begin
              if (half) begin
                rdata[31:16] <= pins.host_data_bus;
              end else begin
                rdata[15:0] <= pins.host_data_bus;
              end
            end
          end
        end
        HPRT_HOLD: begin
          // write data held one cycle past the rising strobe
          state               <= HPRT_GAP;
          pins.host_data_oe_n <= 1'b1;
        end
        HPRT_GAP: begin
          if (high_done) begin
            if (half) begin
              state                 <= HPRT_DONE;
              pins.host_chip_select <= 1'b1;
            end else begin
              state                <= HPRT_SETUP;
              half                 <= 1'b1;
              pins.halfword_select <= 1'b1;
            end
          end
        end
        HPRT_DONE: begin
          state <= HPRT_IDLE;
          busy  <= 1'b0;
          done  <= 1'b1;
        end
        default: state <= HPRT_IDLE;
      endcase
    end
  end
endmodule

// ===== sim/hprt_checker.sv
// Purpose: concurrent checks on the host port pins
// Assumes: one clock domain, reset active high
// Notes:   the device sees pin edges about 3 cycles late, so windows allow for it
module hprt_checker (
  input logic       core_clk,
  input logic       reset,
  input logic       host_chip_select,
  input logic       host_data_strobe_a,
  input logic       host_data_strobe_b,
  input logic       host_address_strobe,
  input logic [1:0] access_type_select,
  input logic       host_read_write,
  input logic       halfword_select,
  input logic       host_ready_n,
  input logic       host_data_oe_n,
  input logic       dev_data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic stb_n;

  // ----------------------------------------------------------------
  // composite strobe and sequences
  // ----------------------------------------------------------------
  assign stb_n = ~(host_data_strobe_a ^ host_data_strobe_b) | host_chip_select;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_rd_first;
    $fell(stb_n) && host_read_write && access_type_select == 2'h3 && !halfword_select;
  endsequence
  sequence s_data_second;
    $rose(stb_n) && access_type_select[0] && halfword_select && (!host_read_write || access_type_select == 2'h1);
  endsequence
  // second half only: at the first half a busy from earlier traffic may still show
  sequence s_quiet;
    $fell(stb_n) && !access_type_select[0] && halfword_select && !host_ready_n;
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ready_idle;  host_chip_select [*5] |-> !host_ready_n; endproperty
  property p_quiet;       s_quiet |=> !host_ready_n [*6]; endproperty
  property p_rd_busy;     s_rd_first |-> ##[2:6] host_ready_n; endproperty
  property p_wr_busy;     s_data_second |-> ##[2:6] host_ready_n; endproperty
  property p_rd_drive;    $fell(stb_n) && host_read_write |-> ##[3:8] !dev_data_oe_n; endproperty
  property p_rd_release;  $rose(stb_n) |-> ##[2:6] dev_data_oe_n; endproperty
  property p_wr_quiet;    $fell(stb_n) && !host_read_write |-> dev_data_oe_n [*6]; endproperty
  property p_rise_ready;  $rose(stb_n) |-> $past(host_ready_n) == 1'b0; endproperty
  property p_wr_data;     $rose(stb_n) && !host_read_write |-> !host_data_oe_n; endproperty
  property p_sel_hold;
    !stb_n && $past(stb_n) == 1'b0 |-> $stable({access_type_select, host_read_write, halfword_select});
  endproperty
  property p_as_once;     $fell(host_address_strobe) |=> host_address_strobe [*6]; endproperty

  a_ready_idle: assert property (p_ready_idle) else $error("ready not low while deselected");
  a_quiet: assert property (p_quiet) else $error("ready busy on register access");
  a_rd_busy: assert property (p_rd_busy) else $error("no busy on data read");
  a_wr_busy: assert property (p_wr_busy) else $error("no busy after second half");
  a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
  a_rd_release: assert property (p_rd_release) else $error("bus not released");
  a_wr_quiet: assert property (p_wr_quiet) else $error("device drives on write");
  a_rise_ready: assert property (p_rise_ready) else $error("strobe raised while busy");
  a_wr_data: assert property (p_wr_data) else $error("write data gone at rise");
  a_sel_hold: assert property (p_sel_hold) else $error("selects moved in access");
  a_as_once: assert property (p_as_once) else $error("address strobe repeated");
endmodule

// ===== sim/tb.sv
// Purpose: self-checking bench, host end and device end joined by the interface
// Assumes: the bench answers the internal transfer port after dma_lat cycles
// Notes:   fetched words are {~addr[15:0], addr[15:0]} so each address is told apart
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hprt_pkg::*;

  typedef struct packed {
    logic [1:0]  typ;
    logic        wr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [1:0]  cnt;
    logic [31:0] da;
  } hprt_row_t;

  logic        core_clk, reset, start, start_write, use_address_strobe, busy, done;
  logic        dma_req, dma_write, dma_done, last_write, seen;
  logic [1:0]  start_type;
  logic [31:0] start_wdata, rdata, dma_addr, dma_wdata, dma_rdata, last_addr, last_wdata;
  logic [15:0] control_value;
  int          errors, num_checks, nreq, dma_lat, k;

  hprt_row_t rows [8] = '{
    '{2'h2, 1'b1, 32'h0000_0100, 32'h0, 2'h0, 32'h0},
    '{2'h0, 1'b1, 32'h5A5A_5A5A, 32'h0, 2'h0, 32'h0},
    '{2'h0, 1'b0, 32'h0, 32'h0000_5A5A, 2'h0, 32'h0},
    '{2'h2, 1'b0, 32'h0, 32'h0000_0100, 2'h0, 32'h0},
    '{2'h1, 1'b1, 32'hDEAD_BEEF, 32'h0, 2'h1, 32'h0000_0100},
    '{2'h3, 1'b0, 32'h0, 32'hFEFB_0104, 2'h1, 32'h0000_0104},
    '{2'h1, 1'b0, 32'h0, 32'hFEFB_0104, 2'h2, 32'h0000_0108},
    '{2'h1, 1'b0, 32'h0, 32'hFEF7_0108, 2'h1, 32'h0000_010C}
  };

  hprt_if u_hprt_if ();
  hprt_device u_hprt_device (.core_clk, .reset, .pins(u_hprt_if), .dma_req, .dma_write, .dma_addr,
                             .dma_wdata, .dma_done, .dma_rdata, .control_value);
  hprt_host u_hprt_host (.core_clk, .reset, .pins(u_hprt_if), .start, .start_write, .start_type,
                         .use_address_strobe, .start_wdata, .busy, .done, .rdata);
  hprt_checker u_hprt_checker (
    .core_clk, .reset,
    .host_chip_select(u_hprt_if.host_chip_select), .host_data_strobe_a(u_hprt_if.host_data_strobe_a),
    .host_data_strobe_b(u_hprt_if.host_data_strobe_b), .host_address_strobe(u_hprt_if.host_address_strobe),
    .access_type_select(u_hprt_if.access_type_select), .host_read_write(u_hprt_if.host_read_write),
    .halfword_select(u_hprt_if.halfword_select), .host_ready_n(u_hprt_if.host_ready_n),
    .host_data_oe_n(u_hprt_if.host_data_oe_n), .dev_data_oe_n(u_hprt_if.dev_data_oe_n));

  // ----------------------------------------------------------------
  // clock, transfer responder, watchdog
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // a dma_done landing in reset is left in on purpose: the device must ignore it
  initial begin
    dma_done = 1'b0;
    dma_rdata = 32'h0;
    nreq = 0;
    forever begin
      @(posedge core_clk);
      #1;
      if (dma_req === 1'b1) begin
        nreq++;
        last_addr = dma_addr;
        last_wdata = dma_wdata;
        last_write = dma_write;
        repeat (dma_lat - 1) @(posedge core_clk);
        #1 dma_done = 1'b1;
        dma_rdata = {~last_addr[15:0], last_addr[15:0]};
        @(posedge core_clk);
        #1 dma_done = 1'b0;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input logic [1:0] typ, input logic wr, input logic [31:0] wd, input logic as);
    int n;
    start_type = typ;
    start_write = wr;
    start_wdata = wd;
    use_address_strobe = as;
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (done !== 1'b1 && n < 2000);
    chk_bit(done, 1'b1);
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {start, start_write, use_address_strobe} = 3'h0;
    start_type = 2'h0;
    start_wdata = 32'h0;
    errors = 0;
    num_checks = 0;
    dma_lat = 3;
    repeat (8) @(posedge core_clk);
    #1 reset = 1'b0;
    chk_bit(u_hprt_if.host_ready_n, 1'b0);
    foreach (rows[i]) begin
      k = nreq;
      run(rows[i].typ, rows[i].wr, rows[i].wd, i[0]);
      if (!rows[i].wr) chk_word(rdata, rows[i].rd);
      chk_word(32'(nreq - k), {30'h0, rows[i].cnt});
      if (rows[i].cnt != 2'h0) chk_word(last_addr, rows[i].da);
      if (rows[i].wr && rows[i].typ[0]) chk_word(last_wdata, rows[i].wd);
    end
    // slow transfer: the next selection must see busy until it completes
    dma_lat = 60;
    run(TYPE_DATA_FIX, 1'b1, 32'h0BAD_F00D, 1'b0);
    chk_bit(last_write, 1'b1);
    chk_word(last_wdata, 32'h0BAD_F00D);
    chk_word(last_addr, 32'h0000_0110);
    // deselected while the store still runs: ready must be forced low
    repeat (8) @(posedge core_clk);
    #1 chk_bit(u_hprt_if.host_ready_n, 1'b0);
    seen = 1'b0;
    fork
      // both halves land in the control register, so both carry the same value
      run(TYPE_CONTROL, 1'b1, 32'hC3C3_C3C3, 1'b1);
      repeat (12) begin
        @(posedge core_clk);
        #1 if (u_hprt_if.host_chip_select === 1'b0 && u_hprt_if.host_ready_n === 1'b1) seen = 1'b1;
      end
    join
    chk_bit(seen, 1'b1);
    chk_word({16'h0, control_value}, 32'h0000_C3C3);
    dma_lat = 3;
    // reset in the middle of a data read
    start_type = TYPE_DATA_FIX;
    start_write = 1'b0;
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    repeat (6) @(posedge core_clk);
    #1 reset = 1'b1;
    #1 chk_bit(u_hprt_if.host_ready_n, 1'b0);
    chk_bit(u_hprt_if.dev_data_oe_n, 1'b1);
    chk_word({16'h0, control_value}, 32'h0);
    chk_bit(busy, 1'b0);
    repeat (3) @(posedge core_clk);
    #1 reset = 1'b0;
    // address register is back at zero, so the fetch answers {16'hFFFF, 16'h0000}
    run(TYPE_DATA_FIX, 1'b0, 32'h0, 1'b0);
    chk_word(rdata, 32'hFFFF_0000);
    run(TYPE_CONTROL, 1'b0, 32'h0, 1'b0);
    chk_word(rdata, 32'h0);
    end_of_test();
  end
endmodule
